// [inc/startup_power_pkg.sv]
/*
  Shared constants and carrier types of the startup and power state control block.
  Assumes one 40 MHz clock domain.
  Command decoding and the digest engine live outside and hand over ready results.
*/
package startup_power_pkg;

  // Bank geometry.
  localparam int DIGEST_W    = 256;
  localparam int REG_COUNT   = 24;
  localparam int SAVED_COUNT = 16;
  localparam int IDX_W       = 5;
  localparam int LOC_W       = 3;

  // Register groups.
  localparam int FIRST_ONES        = 17;
  localparam int LAST_ONES         = 22;
  localparam int LAUNCH_INDEX      = 17;
  localparam int LAUNCH_ZERO_FIRST = 18;
  localparam int LAUNCH_ZERO_LAST  = 22;
  localparam logic [IDX_W-1:0] DEBUG_INDEX = 5'h10;
  localparam logic [IDX_W-1:0] APP_INDEX   = 5'h17;
  localparam logic [IDX_W-1:0] LAST_INDEX  = 5'h17;

  // Reset values.
  localparam logic [DIGEST_W-1:0] ZERO_VALUE = '0;
  localparam logic [DIGEST_W-1:0] ONES_VALUE = '1;

  // Timing.
  localparam int CLOCK_NS       = 25;
  localparam int LP_ENTRY_NS    = 400;
  localparam int LP_ENTRY_COUNT = (LP_ENTRY_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int IDLE_CNT_W     = 5;

  typedef enum logic [1:0] {
    PWR_D0 = 2'b00,
    PWR_D3 = 2'b11
  } power_t;

  typedef enum logic [2:0] {
    CMD_STARTUP_CLEAR  = 3'b000,
    CMD_STARTUP_STATE  = 3'b001,
    CMD_SHUTDOWN_STATE = 3'b010,
    CMD_REG_RESET      = 3'b011,
    CMD_ALTER          = 3'b100,
    CMD_OTHER          = 3'b101
  } cmd_kind_t;

  typedef struct packed {
    logic                 valid;
    cmd_kind_t            kind;
    logic [LOC_W-1:0]     locality;
    logic [IDX_W-1:0]     index;
  } cmd_t;

  typedef struct packed {
    logic valid;
    logic accepted;
    logic success;
  } resp_t;

  typedef struct packed {
    logic                valid;
    logic [DIGEST_W-1:0] digest;
  } launch_t;

  typedef struct packed {
    logic                ran;
    logic [DIGEST_W-1:0] value;
  } root_seq_t;

endpackage

// [core/startup_power_state_control.sv]
/*
  Startup and power state control: measurement register bank, saved state,
  device power state and idle low-power mode.
  Assumes commands arrive decoded and one cycle wide from logic on the same clock;
  the init, power-removal and link power-down pins are asynchronous.
*/
// Function
// - Clearing startup zeroes registers 1-16 and 23, sets 17-22 to all ones.
// - All-ones value spans the full digest width.
// - Without root sequence, register 0 takes the startup locality.
// - With root sequence, register 0 takes the sequence result.
// - Launch hash-end updates 17, zeroes 18-22, leaves 0-16 and 23.
// - Register reset command zeroes 16 and 23 only.
// - After init signal the device is in D0.
// - Every command is refused outside D0.
// - D3 is left only through the init signal.
// - State-saving shutdown leaves the power state unchanged.
// - Shutdown saves state; a later altering command voids it.
// - Startup command selects restoring or clearing the state.
// - Link power management is disabled when its pin is strapped high.
// - Low power only while idle; interface stays active.
// - A request to Ready is honoured within the ready timeout.
// - The Ready transaction itself ends low power; no extra signal.
// - No low power between init signal and first startup.
`timescale 1ns/1ps
`default_nettype none

module startup_power_state_control
  import startup_power_pkg::*;
(
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             rst,
  // Asynchronous pins.
  input  wire logic             device_init_signal,
  input  wire logic             power_removed,
  input  wire logic             link_pd_n,
  // Command, launch and root sequence inputs.
  input  wire cmd_t             cmd,
  input  wire launch_t          launch,
  input  wire root_seq_t        root,
  // Interface state requests.
  input  wire logic             go_ready,
  input  wire logic             go_idle,
  // Bank read port.
  input  wire logic [IDX_W-1:0] rd_index,
  output logic [DIGEST_W-1:0]   rd_data,
  // Status.
  output resp_t                 resp,
  output power_t                power_state,
  output logic                  started,
  output logic                  saved_valid,
  output logic                  low_power,
  output logic                  if_ready,
  output logic                  link_power_down
);

  typedef struct packed {
    logic                                   init_s1;
    logic                                   init_s2;
    logic                                   init_prev;
    logic                                   off_s1;
    logic                                   off_s2;
    logic                                   pd_s1;
    logic                                   pd_s2;
    power_t                                 power;
    logic                                   started;
    logic                                   saved_valid;
    logic                                   low_power;
    logic                                   if_ready;
    logic                                   pm_enabled;
    logic                                   link_down;
    logic [IDLE_CNT_W-1:0]                  idle_cnt;
    resp_t                                  resp;
    logic [DIGEST_W-1:0]                    rd_data;
    logic [REG_COUNT-1:0][DIGEST_W-1:0]     meas;
    logic [SAVED_COUNT-1:0][DIGEST_W-1:0]   saved;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic   init_rise;
  logic   cmd_go;
  logic   launch_go;
  logic   clear_go;

  function automatic logic [DIGEST_W-1:0] clear_value(input int i);
    clear_value = (i >= FIRST_ONES && i <= LAST_ONES) ? ONES_VALUE : ZERO_VALUE;
  endfunction

  assign init_rise = cur.init_s2 && !cur.init_prev;
  assign cmd_go    = cmd.valid && cur.power == PWR_D0 && !init_rise && !cur.off_s2;
  assign launch_go = launch.valid && cur.power == PWR_D0 && cur.started && !init_rise
                     && !cur.off_s2;

  always_comb begin
    next_cur           = cur;
    next_cur.init_s1   = device_init_signal;
    next_cur.init_s2   = cur.init_s1;
    next_cur.init_prev = cur.init_s2;
    next_cur.off_s1    = power_removed;
    next_cur.off_s2    = cur.off_s1;
    next_cur.pd_s1     = link_pd_n;
    next_cur.pd_s2     = cur.pd_s1;
    next_cur.rd_data   = (rd_index <= LAST_INDEX) ? cur.meas[rd_index] : ZERO_VALUE;
    next_cur.resp      = '0;
    next_cur.link_down = cur.pm_enabled && !cur.pd_s2;

    // Refused commands still get an answer, so the host never waits forever.
    if (cmd.valid) begin
      next_cur.resp.valid    = 1'b1;
      next_cur.resp.accepted = cmd_go;
    end

    if (init_rise) begin
      next_cur.power      = PWR_D0;
      next_cur.started    = 1'b0;
      next_cur.low_power  = 1'b0;
      next_cur.if_ready   = 1'b0;
      next_cur.idle_cnt   = '0;
      // The strap is sampled once per init; high turns the protocol off.
      next_cur.pm_enabled = !cur.pd_s2;
    end else if (cur.power == PWR_D3) begin
      next_cur.low_power = 1'b0;
    end else if (cur.off_s2) begin
      next_cur.power     = PWR_D3;
      next_cur.low_power = 1'b0;
      next_cur.if_ready  = 1'b0;
    end else begin
      // Idle and Ready tracking; the Ready request alone ends low power.
      if (go_ready) begin
        next_cur.if_ready  = 1'b1;
        next_cur.low_power = 1'b0;
        next_cur.idle_cnt  = '0;
      end else if (go_idle) begin
        next_cur.if_ready = 1'b0;
        next_cur.idle_cnt = '0;
      end else if (!cur.if_ready && cur.started && !cur.low_power) begin
        if (cur.idle_cnt == IDLE_CNT_W'(LP_ENTRY_COUNT)) begin
          next_cur.low_power = 1'b1;
        end else begin
          next_cur.idle_cnt = cur.idle_cnt + 1'b1;
        end
      end

      if (launch_go) begin
        next_cur.meas[LAUNCH_INDEX] = launch.digest;
        for (int i = LAUNCH_ZERO_FIRST; i <= LAUNCH_ZERO_LAST; i++) begin
          next_cur.meas[i] = ZERO_VALUE;
        end
      end

      if (cmd_go) begin
        case (cmd.kind)
          CMD_STARTUP_CLEAR: begin
            if (!cur.started) begin
              for (int i = 1; i < REG_COUNT; i++) begin
                next_cur.meas[i] = clear_value(i);
              end
              next_cur.meas[0] = root.ran ? root.value
                : {{(DIGEST_W-LOC_W){1'b0}}, cmd.locality};
              next_cur.started     = 1'b1;
              next_cur.saved_valid = 1'b0;
              next_cur.resp.success = 1'b1;
            end
          end
          CMD_STARTUP_STATE: begin
            // A voided or missing save makes the restore fail and leaves the bank alone.
            if (!cur.started && cur.saved_valid) begin
              for (int i = 0; i < REG_COUNT; i++) begin
                next_cur.meas[i] = (i < SAVED_COUNT) ? cur.saved[i] : clear_value(i);
              end
              next_cur.started      = 1'b1;
              next_cur.resp.success = 1'b1;
            end
          end
          CMD_SHUTDOWN_STATE: begin
            for (int i = 0; i < SAVED_COUNT; i++) begin
              next_cur.saved[i] = cur.meas[i];
            end
            next_cur.saved_valid  = 1'b1;
            next_cur.resp.success = 1'b1;
          end
          CMD_REG_RESET: begin
            if (cur.started && (cmd.index == DEBUG_INDEX || cmd.index == APP_INDEX)) begin
              next_cur.meas[cmd.index] = ZERO_VALUE;
              next_cur.resp.success    = 1'b1;
            end
          end
          CMD_ALTER: begin
            next_cur.saved_valid  = 1'b0;
            next_cur.resp.success = cur.started;
          end
          default: begin
            next_cur.resp.success = cur.started;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur       <= '0;
      cur.power <= PWR_D3;
    end else begin
      cur <= next_cur;
    end
  end

  assign rd_data         = cur.rd_data;
  assign resp            = cur.resp;
  assign power_state     = cur.power;
  assign started         = cur.started;
  assign saved_valid     = cur.saved_valid;
  assign low_power       = cur.low_power;
  assign if_ready        = cur.if_ready;
  assign link_power_down = cur.link_down;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  assign clear_go = cmd_go && cmd.kind == CMD_STARTUP_CLEAR && !cur.started;

  chk_clear_zero_regs: assert property (
    clear_go |=> cur.meas[1] == ZERO_VALUE && cur.meas[16] == ZERO_VALUE
                 && cur.meas[23] == ZERO_VALUE && cur.meas[19] == ONES_VALUE)
    else $error("clearing startup left wrong register values");

  chk_ones_width: assert property (
    clear_go |=> &cur.meas[22] && &cur.meas[17])
    else $error("all-ones value not full width");

  chk_locality_value: assert property (
    clear_go && !root.ran |=> cur.meas[0] == {{(DIGEST_W-LOC_W){1'b0}}, $past(cmd.locality)})
    else $error("register 0 does not hold the locality");

  chk_root_value: assert property (
    clear_go && root.ran |=> cur.meas[0] == $past(root.value))
    else $error("register 0 does not hold the root sequence result");

  chk_launch_regs: assert property (
    launch_go && !cmd_go |=> cur.meas[17] == $past(launch.digest)
      && cur.meas[18] == ZERO_VALUE && cur.meas[0] == $past(cur.meas[0])
      && cur.meas[23] == $past(cur.meas[23]))
    else $error("launch event handled the bank wrongly");

  chk_launch_upper: assert property (
    launch_go |=> cur.meas[20] == ZERO_VALUE && cur.meas[22] == ZERO_VALUE)
    else $error("launch event did not zero registers 20 to 22");

  chk_reg_reset: assert property (
    cmd_go && cmd.kind == CMD_REG_RESET && cur.started && cmd.index == DEBUG_INDEX
      && !launch_go |=> cur.meas[16] == ZERO_VALUE && cur.meas[17] == $past(cur.meas[17])
      && cur.meas[0] == $past(cur.meas[0]))
    else $error("register reset command wrong");

  chk_init_d0: assert property (
    init_rise |=> cur.power == PWR_D0 && !cur.started ##1 cur.power == PWR_D0 || cur.off_s2)
    else $error("init signal did not bring D0");

  chk_refuse_off: assert property (
    cmd.valid && cur.power != PWR_D0 |=> resp.valid && !resp.accepted && !resp.success)
    else $error("command accepted outside D0");

  chk_d3_sticks: assert property (
    cur.power == PWR_D3 && !init_rise |=> cur.power == PWR_D3)
    else $error("left D3 without init signal");

  chk_shutdown_power: assert property (
    cmd_go && cmd.kind == CMD_SHUTDOWN_STATE |=> cur.power == PWR_D0 && cur.saved_valid)
    else $error("shutdown changed power state or did not save");

  chk_alter_voids: assert property (
    cmd_go && cmd.kind == CMD_ALTER |=> !cur.saved_valid)
    else $error("altered saved state not voided");

  // A restore without a valid save must fail and leave started low.
  chk_restore_voided: assert property (
    cmd_go && cmd.kind == CMD_STARTUP_STATE && !cur.saved_valid
      |=> !resp.success && !cur.started)
    else $error("restore succeeded without valid saved state");

  chk_lp_only_idle: assert property (
    cur.low_power |-> !cur.if_ready && cur.power == PWR_D0)
    else $error("low power outside idle");

  chk_ready_exit: assert property (
    go_ready && cur.power == PWR_D0 && !init_rise && !cur.off_s2
      |=> cur.if_ready && !cur.low_power)
    else $error("ready request did not end low power");

  chk_no_early_lp: assert property (
    !cur.started |-> !cur.low_power)
    else $error("low power before first startup");

  chk_pm_strap: assert property (
    init_rise && cur.pd_s2 |=> !cur.pm_enabled ##1 !cur.link_down)
    else $error("strapped pin did not disable power management");

  cov_clear_start: cover property (clear_go ##1 cur.started);
  cov_resume: cover property (
    cmd_go && cmd.kind == CMD_STARTUP_STATE && cur.saved_valid && !cur.started);
  cov_low_power: cover property (cur.low_power ##1 go_ready ##1 cur.if_ready);
  cov_launch: cover property (launch_go);

endmodule

`default_nettype wire

// [verif/host_platform_model.sv]
/*
  Host platform model: issues commands, launch events, interface requests and pin levels.
  Assumes the bench calls its tasks and that the device samples on the rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module host_platform_model
  import startup_power_pkg::*;
(
  // Clock and answer.
  input  wire logic  clock,
  input  wire resp_t resp,
  // Requests.
  output cmd_t       cmd,
  output launch_t    launch,
  output root_seq_t  root,
  output logic       go_ready,
  output logic       go_idle,
  // Pins.
  output logic       device_init_signal,
  output logic       power_removed,
  output logic       link_pd_n
);
  resp_t last;

  initial begin
    {cmd, launch, root, go_ready, go_idle, device_init_signal, power_removed} = '0;
    link_pd_n = 1'b1;
  end

  // Released fields show the inverse of their last value, so stale data is never trusted.
  task automatic send(input cmd_kind_t k, input logic [LOC_W-1:0] l, input logic [IDX_W-1:0] i);
    @(negedge clock);
    cmd <= '{1'b1, k, l, i};
    @(negedge clock);
    // The answer stands for one cycle only, so it is taken before the request is dropped.
    last = resp;
    cmd <= '{1'b0, cmd_kind_t'(~k), ~l, ~i};
  endtask

  task automatic hash_end(input logic [DIGEST_W-1:0] d);
    @(negedge clock);
    launch <= '{1'b1, d};
    @(negedge clock);
    launch <= '{1'b0, ~d};
  endtask

  task automatic request(input logic ready);
    @(negedge clock);
    go_ready <= ready;
    go_idle <= !ready;
    @(negedge clock);
    go_ready <= 1'b0;
    go_idle <= 1'b0;
  endtask

  task automatic set_root(input logic ran, input logic [DIGEST_W-1:0] v);
    @(negedge clock);
    root <= '{ran, v};
  endtask

  task automatic set_pins(input logic pd_n, input logic removed);
    @(negedge clock);
    link_pd_n <= pd_n;
    power_removed <= removed;
  endtask

  task automatic init_pulse();
    @(negedge clock);
    device_init_signal <= 1'b1;
    repeat (8) @(negedge clock);
    device_init_signal <= 1'b0;
    repeat (2) @(negedge clock);
  endtask
endmodule

`default_nettype wire

// [verif/test_startup_power_state_control.sv]
/*
  Self-checking bench for the startup and power state control block.
  Assumes the host platform model drives every command and pin input.
*/
`timescale 1ns/1ps
`default_nettype none

module test_startup_power_state_control;
  import startup_power_pkg::*;

  localparam logic [DIGEST_W-1:0] ROOT_VAL   = {8{32'hC3A5_0F1E}};
  localparam logic [DIGEST_W-1:0] LAUNCH_VAL = {8{32'h5A17_E0D2}};

  logic                clock;
  logic                rst;
  cmd_t                cmd;
  launch_t             launch;
  root_seq_t           root;
  logic                go_ready;
  logic                go_idle;
  logic                device_init_signal;
  logic                power_removed;
  logic                link_pd_n;
  logic [IDX_W-1:0]    rd_index;
  logic [DIGEST_W-1:0] rd_data;
  resp_t               resp;
  power_t              power_state;
  logic                started;
  logic                saved_valid;
  logic                low_power;
  logic                if_ready;
  logic                link_power_down;
  int                  n_mismatch;
  int                  compares;
  int                  cycles;
  logic [DIGEST_W-1:0] mirror [REG_COUNT];

  startup_power_state_control u_startup_power_state_control (
    .clock(clock), .rst(rst), .device_init_signal(device_init_signal),
    .power_removed(power_removed), .link_pd_n(link_pd_n), .cmd(cmd), .launch(launch),
    .root(root), .go_ready(go_ready), .go_idle(go_idle), .rd_index(rd_index),
    .rd_data(rd_data), .resp(resp), .power_state(power_state), .started(started),
    .saved_valid(saved_valid), .low_power(low_power), .if_ready(if_ready),
    .link_power_down(link_power_down)
  );

  host_platform_model u_host_platform_model (
    .clock(clock), .resp(resp), .cmd(cmd), .launch(launch), .root(root),
    .go_ready(go_ready), .go_idle(go_idle), .device_init_signal(device_init_signal),
    .power_removed(power_removed), .link_pd_n(link_pd_n)
  );

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [DIGEST_W-1:0] seen, input logic [DIGEST_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Packs power state, started, saved, low power, ready and link power-down.
  task automatic status(input logic [6:0] exp);
    check(DIGEST_W'({power_state, started, saved_valid, low_power, if_ready, link_power_down}),
          DIGEST_W'(exp));
  endtask

  task automatic issue(input cmd_kind_t k, input logic [LOC_W-1:0] l,
                       input logic [IDX_W-1:0] i, input logic [2:0] exp);
    u_host_platform_model.send(k, l, i);
    check(DIGEST_W'(u_host_platform_model.last), DIGEST_W'(exp));
  endtask

  task automatic clear_mirror(input logic [DIGEST_W-1:0] r0);
    for (int i = 0; i < REG_COUNT; i++) begin
      mirror[i] = (i >= FIRST_ONES && i <= LAST_ONES) ? ONES_VALUE : ZERO_VALUE;
    end
    mirror[0] = r0;
  endtask

  // Indices past the bank read as zero.
  task automatic check_bank();
    for (int i = 0; i < 32; i++) begin
      @(negedge clock);
      rd_index <= IDX_W'(i);
      @(negedge clock);
      check(rd_data, (i < REG_COUNT) ? mirror[i] : ZERO_VALUE);
    end
  endtask

  task automatic power_cycle(input logic pd_n);
    u_host_platform_model.set_pins(pd_n, 1'b1);
    repeat (6) @(negedge clock);
    u_host_platform_model.set_pins(pd_n, 1'b0);
    issue(CMD_OTHER, 3'h0, 5'h00, 3'b100);
    repeat (20) @(negedge clock);
    check(DIGEST_W'(power_state), DIGEST_W'(PWR_D3));
    u_host_platform_model.init_pulse();
    u_host_platform_model.request(1'b1);
  endtask

  task automatic t_off();
    status(7'b11_00000);
    issue(CMD_STARTUP_CLEAR, 3'h2, 5'h00, 3'b100);
    status(7'b11_00000);
  endtask

  // Idle before the first startup must not drop into low power.
  task automatic t_start();
    u_host_platform_model.init_pulse();
    status(7'b00_00000);
    u_host_platform_model.request(1'b0);
    u_host_platform_model.set_pins(1'b0, 1'b0);
    repeat (25) @(negedge clock);
    status(7'b00_00000);
    u_host_platform_model.set_pins(1'b1, 1'b0);
    u_host_platform_model.request(1'b1);
  endtask

  task automatic t_clear();
    issue(CMD_STARTUP_CLEAR, 3'h3, 5'h00, 3'b111);
    clear_mirror(DIGEST_W'(3'h3));
    check_bank();
    status(7'b00_10010);
    issue(CMD_STARTUP_CLEAR, 3'h3, 5'h00, 3'b110);
  endtask

  task automatic t_reg_reset();
    issue(CMD_REG_RESET, 3'h1, DEBUG_INDEX, 3'b111);
    issue(CMD_REG_RESET, 3'h1, APP_INDEX, 3'b111);
    issue(CMD_REG_RESET, 3'h1, 5'h11, 3'b110);
    check_bank();
  endtask

  task automatic t_launch();
    u_host_platform_model.hash_end(LAUNCH_VAL);
    mirror[LAUNCH_INDEX] = LAUNCH_VAL;
    for (int i = LAUNCH_ZERO_FIRST; i <= LAUNCH_ZERO_LAST; i++) begin
      mirror[i] = ZERO_VALUE;
    end
    check_bank();
  endtask

  task automatic t_low_power();
    u_host_platform_model.request(1'b0);
    repeat (10) @(negedge clock);
    status(7'b00_10000);
    repeat (15) @(negedge clock);
    status(7'b00_10100);
    u_host_platform_model.request(1'b1);
    status(7'b00_10010);
  endtask

  task automatic t_save();
    power_cycle(1'b1);
    issue(CMD_SHUTDOWN_STATE, 3'h0, 5'h00, 3'b111);
    issue(CMD_STARTUP_CLEAR, 3'h1, 5'h00, 3'b111);
    issue(CMD_SHUTDOWN_STATE, 3'h0, 5'h00, 3'b111);
    status(7'b00_11010);
    issue(CMD_ALTER, 3'h0, 5'h00, 3'b111);
    status(7'b00_10010);
    power_cycle(1'b1);
    issue(CMD_STARTUP_STATE, 3'h0, 5'h00, 3'b110);
    u_host_platform_model.set_root(1'b1, ROOT_VAL);
    issue(CMD_STARTUP_CLEAR, 3'h1, 5'h00, 3'b111);
    clear_mirror(ROOT_VAL);
    check_bank();
    issue(CMD_SHUTDOWN_STATE, 3'h0, 5'h00, 3'b111);
    issue(CMD_ALTER, 3'h0, 5'h00, 3'b111);
    issue(CMD_SHUTDOWN_STATE, 3'h0, 5'h00, 3'b111);
    power_cycle(1'b1);
    u_host_platform_model.set_root(1'b0, ~ROOT_VAL);
    issue(CMD_STARTUP_STATE, 3'h2, 5'h00, 3'b111);
    check_bank();
  endtask

  // With the strap low at init, power management follows the pin.
  task automatic t_link();
    power_cycle(1'b0);
    repeat (5) @(negedge clock);
    check(DIGEST_W'(link_power_down), DIGEST_W'(1'b1));
    u_host_platform_model.set_pins(1'b1, 1'b0);
    repeat (5) @(negedge clock);
    check(DIGEST_W'(link_power_down), DIGEST_W'(1'b0));
  endtask

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // A hang is cut short well past the several hundred cycles the scenarios need.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    n_mismatch = 0;
    compares = 0;
    cycles = 0;
    rst = 1'b1;
    rd_index = '0;
    repeat (10) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    t_off();
    t_start();
    t_clear();
    t_reg_reset();
    t_launch();
    t_low_power();
    t_save();
    t_link();
    wrap_up();
  end
endmodule

`default_nettype wire
